// File: memory_ordering_fence_tb.sv
// testbench: barrier scenarios against the fence and a load/store model.
// assumes 100 MHz clock; model performs one load and one store per cycle.
`timescale 1ns/1ps
module memory_ordering_fence_tb;
  logic        clk = 0, srst = 1, valid = 0, ld_set = 0;
  logic [31:0] insn = 32'h0000_0000;
  logic [3:0]  ld_n = 4'h0, st_n = 4'h0;
  logic        ldp, stp, idle, done, ill, sl, ss, sa, busy;
  logic [6:0]  mask;
  int          fail_count = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  mofnc_lsu_model i_mofnc_lsu_model (.i_sys_clk(clk), .i_srst(srst), .i_load(ld_set),
    .i_ld_n(ld_n), .i_st_n(st_n), .o_ld_pending(ldp), .o_st_pending(stp), .o_all_idle(idle));
  mofnc_fence i_mofnc_fence (.i_sys_clk(clk), .i_srst(srst), .i_bar_valid(valid),
    .i_bar_insn(insn), .i_ld_pending(ldp), .i_st_pending(stp), .i_all_idle(idle),
    .o_bar_done(done), .o_illegal_insn(ill), .o_bar_mask(mask), .o_stall_load(sl),
    .o_stall_store(ss), .o_stall_all(sa), .o_busy(busy));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // result: {illegal, stalls all/store/load seen, cycles from take to finish}
  task automatic bar(input logic [31:0] w, input logic [3:0] l, s, output logic [7:0] r);
    r = 8'h00;
    @(posedge clk) #1 {valid, insn, ld_set, ld_n, st_n} = {1'b1, w, 1'b1, l, s};
    @(posedge clk) #1 {valid, ld_set} = 2'b00;
    while (!(done || ill) && r[3:0] < 4'hf) begin
      @(posedge clk) #1 r[3:0] = r[3:0] + 4'h1;
      r[6:4] = r[6:4] | {sa, ss, sl};
    end
    r[7] = ill;
  endtask : bar
  task automatic t_nop_illegal;
    logic [7:0] r;
    bar(32'h0000_0000, 4'h3, 4'h3, r);
    chk("nop", 8'h00, r);
    bar(32'h0000_1000, 4'h0, 4'h0, r);
    chk("bit 12", 8'h80, r);
    bar(32'h0000_0081, 4'h3, 4'h0, r);
    chk("bit 7", 8'h80, r);
  endtask : t_nop_illegal
  task automatic t_classes;
    logic [7:0] r;
    for (int b = 0; b < 4; b++) begin
      bar(32'h0000_0001 << b, 4'h3, 4'h5, r);
      chk("class", {2'b00, b[1], !b[1], b[0] ? 4'h6 : 4'h4}, r);
    end
  endtask : t_classes
  task automatic t_combo;
    logic [7:0] r;
    bar(32'h0000_000F, 4'h2, 4'h6, r);
    chk("all classes", 8'h37, r);
    bar(32'h0000_0008, 4'h6, 4'h0, r);
    chk("loads ignored", 8'h01, r);
    bar(32'h0000_0070, 4'h3, 4'h0, r);
    chk("completion", 8'h44, r);
  endtask : t_combo
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ceiling well above the sixty or so cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 srst = 0;
    t_nop_illegal;
    t_classes;
    t_combo;
    complete_run;
  end
endmodule : memory_ordering_fence_tb

// File: mofnc_fence.sv
// mofnc_fence: memory barrier decode, ordering hold and completion wait.
// assumes the load/store path reports outstanding loads and stores of this
// virtual processor only, and that issue honours the stall outputs.
//
// Functional notes
// - order-class mask is instruction bits 3:0; any combination may be set.
// - bit 3: earlier stores visible before any later store becomes visible.
// - bit 2: earlier loads performed before any later store becomes visible.
// - bit 1: earlier stores visible before any later load is performed.
// - bit 0: earlier loads performed before any later load is performed.
// - nonzero completion mask adds completion wait, stricter than ordering alone.
// - covers all own address spaces; never waits on other processors.
// - atomics count as load and store; instruction flush counts as store.
// - load performed once value delivered and no longer changeable.
// - store performed once old value can no longer be read anywhere.
// - ordering judged against strictly sequential execution.
// - combined assembly mask is completion mask above order-class mask.
// - completion mask is instruction bits 6:4.
// - both masks zero makes the barrier a no-operation.
// - nonzero bits 12:7 raise an illegal-instruction exception.
`timescale 1ns/1ps
module mofnc_fence
  import mofnc_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  // barrier issue
  input  wire logic        i_bar_valid,
  input  wire logic [31:0] i_bar_insn,
  // load/store path status, same clock
  input  wire logic        i_ld_pending,
  input  wire logic        i_st_pending,
  input  wire logic        i_all_idle,
  // barrier outcome
  output logic             o_bar_done,
  output logic             o_illegal_insn,
  output logic [6:0]       o_bar_mask,
  // issue stalls for later operations
  output logic             o_stall_load,
  output logic             o_stall_store,
  output logic             o_stall_all,
  output logic             o_busy
);

  logic [3:0]   omask_r;
  logic [2:0]   cmask_r;
  mofnc_state_e state_r;
  logic [3:0]   in_omask;
  logic [2:0]   in_cmask;
  logic         in_rsvd;
  logic         in_nop;
  logic         wait_ld;
  logic         wait_st;
  logic         ld_blocked;
  logic         st_blocked;
  logic         cmpl_blocked;
  logic         release_now;

  // decode straight from the instruction word
  assign in_omask = i_bar_insn[MOFNC_OMASK_LSB +: MOFNC_OMASK_W];
  assign in_cmask = i_bar_insn[MOFNC_CMASK_LSB +: MOFNC_CMASK_W];
  assign in_rsvd  = |i_bar_insn[MOFNC_RSVD_LSB +: MOFNC_RSVD_W];
  assign in_nop   = (in_omask == 4'h0) && (in_cmask == 3'h0);

  // pending flags come from this processor only; atomics raise both and
  // flush raises the store flag inside the load/store path
  assign wait_ld = i_ld_pending;
  assign wait_st = i_st_pending;

  // a later load is held by load_before_load or store_before_load
  assign ld_blocked = (omask_r[MOFNC_BIT_LD_LD] && wait_ld)
                   || (omask_r[MOFNC_BIT_ST_LD] && wait_st);
  // a later store is held by store_before_store or load_before_store
  assign st_blocked = (omask_r[MOFNC_BIT_ST_ST] && wait_st)
                   || (omask_r[MOFNC_BIT_LD_ST] && wait_ld);
  // completion drains everything, stricter than the classes alone
  assign cmpl_blocked = (cmask_r != 3'h0) && !i_all_idle;

  assign release_now = !ld_blocked && !st_blocked && !cmpl_blocked;

  // held masks; exposed as the combined assembly form
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      omask_r <= MOFNC_OMASK_RST;
      cmask_r <= MOFNC_CMASK_RST;
    end else if (state_r == MOFNC_IDLE && i_bar_valid && !in_rsvd && !in_nop) begin
      omask_r <= in_omask;
      cmask_r <= in_cmask;
    end else if (state_r == MOFNC_HOLD && release_now) begin
      omask_r <= MOFNC_OMASK_RST;
      cmask_r <= MOFNC_CMASK_RST;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= MOFNC_IDLE;
    end else begin
      unique case (state_r)
        MOFNC_IDLE: begin
          if (i_bar_valid && !in_rsvd && !in_nop) begin
            state_r <= MOFNC_HOLD;
          end
        end
        MOFNC_HOLD: begin
          if (release_now) begin
            state_r <= MOFNC_IDLE;
          end
        end
        default: state_r <= MOFNC_IDLE;
      endcase
    end
  end

  // one-cycle outcome pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_bar_done     <= 1'b0;
      o_illegal_insn <= 1'b0;
    end else begin
      o_illegal_insn <= (state_r == MOFNC_IDLE) && i_bar_valid && in_rsvd;
      o_bar_done     <= ((state_r == MOFNC_IDLE) && i_bar_valid && !in_rsvd && in_nop)
                     || ((state_r == MOFNC_HOLD) && release_now);
    end
  end

  // registered stalls; while a barrier is held, issue of the constrained
  // class stops. costs one cycle of latency but keeps outputs glitch free
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_stall_load  <= 1'b0;
      o_stall_store <= 1'b0;
      o_stall_all   <= 1'b0;
      o_busy        <= 1'b0;
      o_bar_mask    <= 7'h00;
    end else begin
      o_stall_load  <= (state_r == MOFNC_HOLD) && !release_now && ld_blocked;
      o_stall_store <= (state_r == MOFNC_HOLD) && !release_now && st_blocked;
      o_stall_all   <= (state_r == MOFNC_HOLD) && !release_now && cmpl_blocked;
      o_busy        <= (state_r == MOFNC_HOLD) && !release_now;
      o_bar_mask    <= {cmask_r, omask_r};
    end
  end

endmodule : mofnc_fence

// File: mofnc_fence_props.sv
// checker: port-level timing of the fence block.
// assumes one clock domain and no barrier offered in the cycle after a take.
`timescale 1ns/1ps
module mofnc_fence_props (
  input wire logic        i_sys_clk, i_srst, i_bar_valid, i_ld_pending, i_st_pending,
  input wire logic        i_all_idle, o_bar_done, o_illegal_insn, o_stall_load,
  input wire logic        o_stall_store, o_stall_all, o_busy,
  input wire logic [31:0] i_bar_insn,
  input wire logic [6:0]  o_bar_mask
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_take; i_bar_valid && !o_busy; endsequence
  sequence s_legal; s_take ##0 i_bar_insn[12:7] == 0 && i_bar_insn[6:0] != 0; endsequence
  property p_illegal; s_take ##0 i_bar_insn[12:7] != 0 |=> o_illegal_insn && !o_busy; endproperty
  a_illegal: assert property (p_illegal) else $error("illegal pulse missing");
  property p_nop; s_take ##0 i_bar_insn[12:0] == 0 |=> o_bar_done && !o_illegal_insn; endproperty
  a_nop: assert property (p_nop) else $error("nop not done at once");
  property p_hold; s_legal |=> !o_bar_done ##1 (o_busy || o_bar_done)
    && o_bar_mask == $past(i_bar_insn[6:0], 2);
  endproperty
  a_hold: assert property (p_hold) else $error("held mask wrong");
  property p_st_st; o_busy && o_bar_mask[3] && $past(i_st_pending) |-> o_stall_store; endproperty
  a_st_st: assert property (p_st_st) else $error("store stall missing");
  property p_ld_st; o_busy && o_bar_mask[2] && $past(i_ld_pending) |-> o_stall_store; endproperty
  a_ld_st: assert property (p_ld_st) else $error("store stall missing");
  property p_st_ld; o_busy && o_bar_mask[1] && $past(i_st_pending) |-> o_stall_load; endproperty
  a_st_ld: assert property (p_st_ld) else $error("load stall missing");
  property p_ld_ld; o_busy && o_bar_mask[0] && $past(i_ld_pending) |-> o_stall_load; endproperty
  a_ld_ld: assert property (p_ld_ld) else $error("load stall missing");
  property p_cmpl; o_busy && o_bar_mask[6:4] != 0 && !i_all_idle |=> !o_bar_done; endproperty
  a_cmpl: assert property (p_cmpl) else $error("done before idle");
  property p_stw; o_busy && (o_bar_mask[3] || o_bar_mask[1]) && i_st_pending |=> !o_bar_done;
  endproperty
  a_stw: assert property (p_stw) else $error("done with stores pending");
endmodule : mofnc_fence_props
bind mofnc_fence mofnc_fence_props i_mofnc_fence_props (.*);

// File: mofnc_lsu_model.sv
// load/store model: counts outstanding loads and stores of one processor.
// assumes the bench loads the counts in the barrier's take cycle.
`timescale 1ns/1ps
module mofnc_lsu_model (
  input  wire logic       i_sys_clk, i_srst, i_load,
  input  wire logic [3:0] i_ld_n, i_st_n,
  output logic            o_ld_pending, o_st_pending, o_all_idle
);
  logic [3:0] ld_r, st_r;
  // one load and one store performed per cycle; an atomic sits in both counts
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) {ld_r, st_r} <= 8'h00;
    else if (i_load) {ld_r, st_r} <= {i_ld_n, i_st_n};
    else {ld_r, st_r} <= {ld_r - 4'(|ld_r), st_r - 4'(|st_r)};
  end
  assign o_ld_pending = |ld_r;
  assign o_st_pending = |st_r;
  assign o_all_idle   = !(|ld_r || |st_r);
endmodule : mofnc_lsu_model

// File: mofnc_pkg.sv
// mofnc_pkg: field positions and constants for the memory ordering fence block.
// assumes a single core clock domain; no register bus.
package mofnc_pkg;
  localparam int MOFNC_INSN_W       = 32;
  localparam int MOFNC_OMASK_LSB    = 0;
  localparam int MOFNC_OMASK_W      = 4;
  localparam int MOFNC_CMASK_LSB    = 4;
  localparam int MOFNC_CMASK_W      = 3;
  localparam int MOFNC_RSVD_LSB     = 7;
  localparam int MOFNC_RSVD_W       = 6;
  localparam int MOFNC_BIT_ST_ST    = 3;
  localparam int MOFNC_BIT_LD_ST    = 2;
  localparam int MOFNC_BIT_ST_LD    = 1;
  localparam int MOFNC_BIT_LD_LD    = 0;
  localparam logic [3:0] MOFNC_OMASK_RST = 4'h0;
  localparam logic [2:0] MOFNC_CMASK_RST = 3'h0;
  typedef enum logic [1:0] {
    MOFNC_IDLE,
    MOFNC_HOLD
  } mofnc_state_e;
endpackage : mofnc_pkg
